// *** hdl/pmcfg_pkg.sv ***
// Purpose: constants and carrier types for the configuration header bank
// Assumes: byte addresses within a 256-byte configuration space, dword access
// Notes: dword offsets are byte addresses of the containing dword, field offsets are byte addresses of the field
package pmcfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // dword offsets
  localparam logic [7:0] OFF_SUBSYS = 8'h2C;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_IRQ = 8'h3C;
  localparam logic [7:0] OFF_PM_CAP = 8'h70;

  // byte offsets of the sub-dword fields
  localparam logic [7:0] OFF_SUBSYS_ID = 8'h2E;
  localparam logic [7:0] OFF_IRQ_PIN = 8'h3D;
  localparam logic [7:0] OFF_MIN_GNT = 8'h3E;
  localparam logic [7:0] OFF_MAX_LAT = 8'h3F;
  localparam logic [7:0] OFF_PM_WORD = 8'h72;
  localparam logic [7:0] OFF_SSV_HI = 8'h2D;
  localparam logic [7:0] OFF_SSID_HI = 8'h2F;
  localparam logic [7:0] OFF_PM_WORD_HI = 8'h73;

  // constant fields
  localparam logic [7:0] CAP_PTR_VAL = 8'h70;
  localparam logic [7:0] CAPABILITY_CODE = 8'h01;
  localparam logic [7:0] NEXT_CAP_PTR = 8'h00;

  // reset values
  localparam logic [15:0] SUBSYS_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] PIN_RST = 4'h0;
  localparam logic [15:0] PM_WORD_RST = 16'h0000;

  // power capability word layout
  localparam int PMW_WAKE_D0 = 15;
  localparam int PMW_WAKE_D1 = 14;
  localparam int PMW_WAKE_D2 = 13;
  localparam int PMW_WAKE_D3H = 12;
  localparam int PMW_WAKE_D3C = 11;
  localparam int PMW_D2_SUP = 10;
  localparam int PMW_D1_SUP = 9;
  localparam int PMW_INIT_REQ = 5;
  localparam int PMW_AUX_PWR = 4;
  localparam int PMW_CLK_DEP = 3;
  localparam int PMW_VER_HI = 2;
  localparam int PMW_VER_LO = 0;
  // bits 8:6 are reserved and stay zero
  localparam logic [15:0] PM_WORD_MASK = 16'hFE3F;
  localparam logic [3:0] PIN_MASK = 4'hF;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] wdata;
  } pmcfg_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } pmcfg_rsp_t;

endpackage

// *** hdl/pmcfg_port.sv ***
// Purpose: registered answer stage for one access port of the bank
// Assumes: request and read word arrive on sys_clk, no crossing needed
// Notes: ack is a one-cycle pulse one edge after a selected request
`timescale 1ns/1ps
module pmcfg_port
(
  input wire logic sys_clk, // device clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic req_sel, // request present this cycle
  input wire logic [pmcfg_pkg::DATA_W-1:0] rd_word, // decoded read word
  output pmcfg_pkg::pmcfg_rsp_t rsp_r // registered answer
);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rsp_r <= '0;
    end
    else
    begin
      rsp_r.ack <= req_sel;
      if (req_sel)
      begin
        rsp_r.rdata <= rd_word;
      end
    end
  end

endmodule // pmcfg_port

// *** hdl/pmcfg_bank.sv ***
// Purpose: configuration header fields and power capability entry
// Assumes: local core and configuration host share sys_clk (40 MHz)
// Notes: core port may write everything writable; host port is limited
// Overview of operation
// - Capability pointer reads 70h in its low byte, zero above, and ignores writes.
// - Subsystem vendor word at 2Ch is plain read/write storage reset to zero.
// - Subsystem word at 2Eh, bits 31:16, is plain read/write storage reset to zero.
// - Interrupt routing line at 3Ch is plain read/write storage reset to zero.
// - Interrupt pin bits 11:8 are written only by the core, bits 15:12 read zero.
// - Minimum grant hint bits 23:16 are core-writable, host read-only, reset zero.
// - Latency hint bits 31:24 are core-writable, host read-only, reset zero.
// - Capability header low byte always reads 01h and ignores writes.
// - Next-capability byte in bits 15:8 of the header always reads zero.
// - Power capability word at 72h is core-writable, host read-only, bits 8:6 zero.
// - Reset clears every bit of the power capability word.
// - Word layout: wake flags 15:11, D2 10, D1 9, init 5, aux 4, clock 3, version 2:0.
`timescale 1ns/1ps
module pmcfg_bank
(
  input wire logic sys_clk, // device clock, 40 MHz
  input wire logic rst_n, // synchronous reset, active low
  input pmcfg_pkg::pmcfg_req_t core_req, // local core access
  output pmcfg_pkg::pmcfg_rsp_t core_rsp, // local core answer
  input pmcfg_pkg::pmcfg_req_t host_req, // configuration host access
  output pmcfg_pkg::pmcfg_rsp_t host_rsp, // configuration host answer
  output logic [15:0] pm_word_r // power capability word, for status
);

  logic [15:0] ssvid_r;
  logic [15:0] ssid_r;
  logic [7:0] irq_line_r;
  logic [3:0] irq_pin_r;
  logic [7:0] min_gnt_r;
  logic [7:0] max_lat_r;
  logic [15:0] pm_word_nxt;
  logic [pmcfg_pkg::DATA_W-1:0] core_word;
  logic [pmcfg_pkg::DATA_W-1:0] host_word;
  // lane write strobes, core side
  logic core_ssv_lo;
  logic core_ssv_hi;
  logic core_ss_lo;
  logic core_ss_hi;
  logic core_line;
  logic core_pin;
  logic core_gnt;
  logic core_lat;
  logic core_pmw_lo;
  logic core_pmw_hi;
  // lane write strobes, host side, shared fields only
  logic host_ssv_lo;
  logic host_ssv_hi;
  logic host_ss_lo;
  logic host_ss_hi;
  logic host_line;

  // byte-lane merge of new data into a stored byte
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  // dword match of a byte address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  // write strobe for a field held in a given byte lane
  function automatic logic lane_wr(input pmcfg_pkg::pmcfg_req_t rq, input logic [7:0] off,
                                   input logic [7:0] fld);
    lane_wr = rq.sel && rq.wr && hit(rq.addr, off) && rq.be[fld[1:0]];
  endfunction

  // read decode shared by both ports
  function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [15:0] ssv,
                                            input logic [15:0] ss, input logic [7:0] il,
                                            input logic [3:0] ip, input logic [7:0] mg,
                                            input logic [7:0] ml, input logic [15:0] pw);
    read_word = 32'h0000_0000;
    if (hit(addr, pmcfg_pkg::OFF_CAP_PTR))
    begin
      read_word = {24'h00_0000, pmcfg_pkg::CAP_PTR_VAL};
    end
    else if (hit(addr, pmcfg_pkg::OFF_SUBSYS))
    begin
      read_word = {ss, ssv};
    end
    else if (hit(addr, pmcfg_pkg::OFF_IRQ))
    begin
      read_word = {ml, mg, 4'h0, ip, il};
    end
    else if (hit(addr, pmcfg_pkg::OFF_PM_CAP))
    begin
      read_word = {pw & pmcfg_pkg::PM_WORD_MASK, pmcfg_pkg::NEXT_CAP_PTR,
                   pmcfg_pkg::CAPABILITY_CODE};
    end
  endfunction

  // defined fields of the power word only, 8:6 left clear
  function automatic logic [15:0] pm_layout(input logic [15:0] w);
    pm_layout = pmcfg_pkg::PM_WORD_RST;
    pm_layout[pmcfg_pkg::PMW_WAKE_D0:pmcfg_pkg::PMW_WAKE_D3C] =
      w[pmcfg_pkg::PMW_WAKE_D0:pmcfg_pkg::PMW_WAKE_D3C];
    pm_layout[pmcfg_pkg::PMW_D2_SUP] = w[pmcfg_pkg::PMW_D2_SUP];
    pm_layout[pmcfg_pkg::PMW_D1_SUP] = w[pmcfg_pkg::PMW_D1_SUP];
    pm_layout[pmcfg_pkg::PMW_INIT_REQ] = w[pmcfg_pkg::PMW_INIT_REQ];
    pm_layout[pmcfg_pkg::PMW_AUX_PWR] = w[pmcfg_pkg::PMW_AUX_PWR];
    pm_layout[pmcfg_pkg::PMW_CLK_DEP] = w[pmcfg_pkg::PMW_CLK_DEP];
    pm_layout[pmcfg_pkg::PMW_VER_HI:pmcfg_pkg::PMW_VER_LO] =
      w[pmcfg_pkg::PMW_VER_HI:pmcfg_pkg::PMW_VER_LO];
  endfunction

  always_comb
  begin
    core_ssv_lo = lane_wr(core_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SUBSYS);
    core_ssv_hi = lane_wr(core_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SSV_HI);
    core_ss_lo = lane_wr(core_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SUBSYS_ID);
    core_ss_hi = lane_wr(core_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SSID_HI);
    core_line = lane_wr(core_req, pmcfg_pkg::OFF_IRQ, pmcfg_pkg::OFF_IRQ);
    core_pin = lane_wr(core_req, pmcfg_pkg::OFF_IRQ, pmcfg_pkg::OFF_IRQ_PIN);
    core_gnt = lane_wr(core_req, pmcfg_pkg::OFF_IRQ, pmcfg_pkg::OFF_MIN_GNT);
    core_lat = lane_wr(core_req, pmcfg_pkg::OFF_IRQ, pmcfg_pkg::OFF_MAX_LAT);
    core_pmw_lo = lane_wr(core_req, pmcfg_pkg::OFF_PM_CAP, pmcfg_pkg::OFF_PM_WORD);
    core_pmw_hi = lane_wr(core_req, pmcfg_pkg::OFF_PM_CAP, pmcfg_pkg::OFF_PM_WORD_HI);
  end

  // host strobes only for host-writable fields
  always_comb
  begin
    host_ssv_lo = lane_wr(host_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SUBSYS);
    host_ssv_hi = lane_wr(host_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SSV_HI);
    host_ss_lo = lane_wr(host_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SUBSYS_ID);
    host_ss_hi = lane_wr(host_req, pmcfg_pkg::OFF_SUBSYS, pmcfg_pkg::OFF_SSID_HI);
    host_line = lane_wr(host_req, pmcfg_pkg::OFF_IRQ, pmcfg_pkg::OFF_IRQ);
  end

  // vendor word, writable from both ports, core wins a tie
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ssvid_r <= pmcfg_pkg::SUBSYS_RST;
    end
    else
    begin
      if (core_ssv_lo)
      begin
        ssvid_r[7:0] <= core_req.wdata[7:0];
      end
      else if (host_ssv_lo)
      begin
        ssvid_r[7:0] <= host_req.wdata[7:0];
      end
      if (core_ssv_hi)
      begin
        ssvid_r[15:8] <= core_req.wdata[15:8];
      end
      else if (host_ssv_hi)
      begin
        ssvid_r[15:8] <= host_req.wdata[15:8];
      end
    end
  end

  // subsystem word in the upper half
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ssid_r <= pmcfg_pkg::SUBSYS_RST;
    end
    else
    begin
      if (core_ss_lo)
      begin
        ssid_r[7:0] <= core_req.wdata[23:16];
      end
      else if (host_ss_lo)
      begin
        ssid_r[7:0] <= host_req.wdata[23:16];
      end
      if (core_ss_hi)
      begin
        ssid_r[15:8] <= core_req.wdata[31:24];
      end
      else if (host_ss_hi)
      begin
        ssid_r[15:8] <= host_req.wdata[31:24];
      end
    end
  end

  // routing line, writable from both ports
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq_line_r <= pmcfg_pkg::BYTE_RST;
    end
    else if (core_line)
    begin
      irq_line_r <= core_req.wdata[7:0];
    end
    else if (host_line)
    begin
      irq_line_r <= host_req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq_pin_r <= pmcfg_pkg::PIN_RST;
    end
    else if (core_pin)
    begin
      irq_pin_r <= core_req.wdata[11:8] & pmcfg_pkg::PIN_MASK;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      min_gnt_r <= pmcfg_pkg::BYTE_RST;
    end
    else
    begin
      min_gnt_r <= merge8(min_gnt_r, core_req.wdata[23:16], core_gnt);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      max_lat_r <= pmcfg_pkg::BYTE_RST;
    end
    else
    begin
      max_lat_r <= merge8(max_lat_r, core_req.wdata[31:24], core_lat);
    end
  end

  always_comb
  begin
    pm_word_nxt = pm_word_r;
    if (core_pmw_lo)
    begin
      pm_word_nxt[7:0] = core_req.wdata[23:16];
    end
    if (core_pmw_hi)
    begin
      pm_word_nxt[15:8] = core_req.wdata[31:24];
    end
    pm_word_nxt = pm_layout(pm_word_nxt);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pm_word_r <= pmcfg_pkg::PM_WORD_RST;
    end
    else
    begin
      pm_word_r <= pm_word_nxt;
    end
  end

  always_comb
  begin
    core_word = read_word(core_req.addr, ssvid_r, ssid_r, irq_line_r, irq_pin_r,
                          min_gnt_r, max_lat_r, pm_word_r);
  end

  always_comb
  begin
    host_word = read_word(host_req.addr, ssvid_r, ssid_r, irq_line_r, irq_pin_r,
                          min_gnt_r, max_lat_r, pm_word_r);
  end

  pmcfg_port u_core_port
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_sel(core_req.sel),
    .rd_word(core_word),
    .rsp_r(core_rsp)
  );

  // host writes acknowledged like any access
  pmcfg_port u_host_port
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_sel(host_req.sel),
    .rd_word(host_word),
    .rsp_r(host_rsp)
  );

endmodule // pmcfg_bank

// *** verification/pmcfg_asserts.sv ***
// Purpose: port assertions for the header bank
// Assumes: one sys_clk domain
// Notes: bound to pmcfg_bank
`timescale 1ns/1ps
module pmcfg_asserts
(
  input wire logic sys_clk, // device clock
  input wire logic rst_n, // sync reset, active low
  input pmcfg_pkg::pmcfg_req_t core_req, // core access
  input pmcfg_pkg::pmcfg_rsp_t core_rsp, // core answer
  input pmcfg_pkg::pmcfg_req_t host_req, // host access
  input pmcfg_pkg::pmcfg_rsp_t host_rsp, // host answer
  input wire logic [15:0] pm_word_r // power word
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire host_rd = host_req.sel && !host_req.wr;
  wire rd_cap = host_rd && host_req.addr[7:2] == 6'h1C;
  wire rd_ptr = host_rd && host_req.addr[7:2] == 6'h0D;
  wire rd_irq = host_rd && host_req.addr[7:2] == 6'h0F;
  wire host_wr = host_req.sel && host_req.wr && !core_req.sel;
  wire all_clear = pm_word_r == 16'h0000 && !host_rsp.ack && !core_rsp.ack;
  host_ack_a: assert property (host_req.sel |=> host_rsp.ack)
    else $error("host ack missing");
  core_ack_a: assert property (core_req.sel |=> core_rsp.ack)
    else $error("core ack missing");
  cap_ptr_a: assert property (rd_ptr |=> host_rsp.rdata == 32'h0000_0070)
    else $error("pointer read wrong");
  cap_hdr_a: assert property (rd_cap |=> host_rsp.rdata[15:0] == 16'h0001)
    else $error("header read wrong");
  pm_read_a: assert property (rd_cap |=> host_rsp.rdata[31:16] == $past(pm_word_r))
    else $error("power word read wrong");
  pm_rsvd_a: assert property (pm_word_r[8:6] == 3'h0)
    else $error("reserved bits set");
  pm_host_ro_a: assert property (host_wr |=> $stable(pm_word_r))
    else $error("host changed power word");
  pin_hi_a: assert property (rd_irq |=> host_rsp.rdata[15:12] == 4'h0)
    else $error("pin upper bits set");
  reset_clr_a: assert property (disable iff (1'b0) !rst_n |=> all_clear)
    else $error("reset not clearing");
  cover property (rd_cap);
  cover property (core_req.sel && core_req.wr && core_req.addr == 8'h3C);
  cover property (host_req.sel && host_req.wr);
  cover property (core_req.sel && core_req.wr && host_req.sel && host_req.wr);
endmodule // pmcfg_asserts
bind pmcfg_bank pmcfg_asserts pmcfg_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .core_req(core_req), .core_rsp(core_rsp), .host_req(host_req),
  .host_rsp(host_rsp), .pm_word_r(pm_word_r));

// *** verification/pmcfg_host.sv ***
// Purpose: configuration host model
// Assumes: one request per access, answer one edge later
// Notes: released lines carry inverted values
`timescale 1ns/1ps
module pmcfg_host
(
  input wire logic sys_clk, // device clock
  output pmcfg_pkg::pmcfg_req_t host_req, // request to bank
  input pmcfg_pkg::pmcfg_rsp_t host_rsp // answer from bank
);
  initial host_req = '0;
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk);
    #2;
    host_req = '{1'b1, wr, a, be, d};
    @(posedge sys_clk);
    #2;
    // no stale value once released
    host_req = '{1'b0, ~wr, ~a, ~be, ~d};
    rd = host_rsp.ack ? host_rsp.rdata : ~host_rsp.rdata;
  endtask
endmodule // pmcfg_host

// *** verification/tb.sv ***
// Purpose: self-checking bench for the header bank
// Assumes: 40 MHz sys_clk, host model on the host port
// Notes: rows are core writes read back by the host
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pmcfg_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  pmcfg_pkg::pmcfg_req_t core_req = '0;
  pmcfg_pkg::pmcfg_req_t host_req;
  pmcfg_pkg::pmcfg_rsp_t core_rsp;
  pmcfg_pkg::pmcfg_rsp_t host_rsp;
  logic [15:0] pm_word;
  logic [31:0] rd;
  logic [31:0] crd;
  int num_errors = 0;
  int n_checks = 0;
  pmcfg_row_t rows [5] = '{'{8'h2C, 32'h1234_5678, 32'h1234_5678},
    '{8'h3C, 32'hA5B3_F122, 32'hA5B3_0122}, '{8'h34, 32'hFFFF_FFFF, 32'h0000_0070},
    '{8'h70, 32'hFFFF_FFFF, 32'hFE3F_0001}, '{8'h80, 32'hFFFF_FFFF, 32'h0000_0000}};
  pmcfg_bank pmcfg_bank_inst (.sys_clk(sys_clk), .rst_n(rst_n), .core_req(core_req),
    .core_rsp(core_rsp), .host_req(host_req), .host_rsp(host_rsp), .pm_word_r(pm_word));
  pmcfg_host pmcfg_host_inst (.sys_clk(sys_clk), .host_req(host_req), .host_rsp(host_rsp));
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic core_acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] crd);
    @(posedge sys_clk);
    #2;
    core_req = '{1'b1, wr, a, be, d};
    @(posedge sys_clk);
    #2;
    core_req.sel = 1'b0;
    crd = core_rsp.rdata;
    check({31'h0, core_rsp.ack}, 32'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // limit well above the roughly 60 cycles the tests need
  initial
  begin
    #20000;
    num_errors = num_errors + 1;
    give_verdict();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      core_acc(1'b1, rows[i].a, 4'hF, rows[i].d, crd);
      pmcfg_host_inst.acc(1'b0, rows[i].a, 4'h0, 32'h0, rd);
      check(rd, rows[i].e);
      $display("row %0d done", i);
    end
    pmcfg_host_inst.acc(1'b1, 8'h3C, 4'hF, 32'hFFFF_FFFF, rd);
    pmcfg_host_inst.acc(1'b0, 8'h3C, 4'h0, 32'h0, rd);
    check(rd, 32'hA5B3_01FF);
    core_acc(1'b0, 8'h3C, 4'h0, 32'h0, crd);
    check(crd, 32'hA5B3_01FF);
    pmcfg_host_inst.acc(1'b1, 8'h70, 4'hF, 32'h0000_0000, rd);
    pmcfg_host_inst.acc(1'b0, 8'h70, 4'h0, 32'h0, rd);
    check(rd, 32'hFE3F_0001);
    $display("host write test done");
    // same-cycle writes to the vendor word, core lane wins
    fork
      core_acc(1'b1, 8'h2C, 4'h1, 32'h0000_00AA, crd);
      pmcfg_host_inst.acc(1'b1, 8'h2C, 4'hF, 32'h9ABC_55BB, rd);
    join
    pmcfg_host_inst.acc(1'b0, 8'h2C, 4'h0, 32'h0, rd);
    check(rd, 32'h9ABC_55AA);
    $display("shared write test done");
    core_acc(1'b1, 8'h70, 4'hC, 32'h85C5_1234, crd);
    check({16'h0, pm_word}, 32'h0000_8405);
    core_acc(1'b0, 8'h70, 4'h0, 32'h0, crd);
    check(crd, 32'h8405_0001);
    $display("layout test done");
    @(posedge sys_clk);
    #2;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    check({16'h0, pm_word}, 32'h0);
    pmcfg_host_inst.acc(1'b0, 8'h3C, 4'h0, 32'h0, rd);
    check(rd, 32'h0);
    pmcfg_host_inst.acc(1'b0, 8'h2C, 4'h0, 32'h0, rd);
    check(rd, 32'h0);
    pmcfg_host_inst.acc(1'b0, 8'h70, 4'h0, 32'h0, rd);
    check(rd, 32'h0000_0001);
    $display("reset test done");
    give_verdict();
  end
endmodule // tb
